// file: design/tei_removal_verify_codec.sv
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "tei_codec_params.svh"
//////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Remove commands link to TEI-unassigned state
// - Release confirm if pending, else indication if multiple frame established
// - Flush UI and I queues, then unassigned
// - Remove on remove, disconnect, link error
// - Optionally remove on duplicate assigned TEI
// - Verify carries type 07, TEI, zero Ri
// - Matching check request stops T202
// - Expiry resends once, second expiry removes
// - Messages use UI command, SAPI 63, TEI 127
// - Unused fields sent zero, ignored on receipt
// - First octet is entity identifier 0F
// - Reference number in octets two and three
// - Octet four holds the message type code
// - Ai bit 1 extension, bits 2-8 value
// - Multi-octet Ai only in full check response
// - Ai ranges per message type
// - After removal start assignment or flag user
// - Answer check request with TEI, random Ri
// - Group check answered by one full list
//////////////////////////////////////////////////////////////////////////////////////////
module tei_removal_verify_codec #(
    parameter int unsigned T202_CYC = `T202_CYC
) (
    // Clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    // Register port
    input  wire logic [3:0]               reg_addr_i,
    input  wire logic [31:0]              reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    output logic      [31:0]              reg_rdata_o,
    // Received management frames
    input  wire tei_codec_pkg::frame_hdr_t rx_hdr_i,
    input  wire logic                     rx_valid_i,
    input  wire logic                     rx_sof_i,
    input  wire logic                     rx_eof_i,
    input  wire logic [7:0]               rx_data_i,
    // Transmitted management frames
    output tei_codec_pkg::frame_hdr_t     tx_hdr_o,
    output tei_codec_pkg::tx_octet_t      tx_o,
    input  wire logic                     tx_ready_i,
    // Link events
    input  wire logic                     phy_disc_i,
    input  wire logic                     mdl_multi_err_i,
    input  wire logic                     dl_rel_req_i,
    input  wire logic                     dl_mf_est_i,
    // Link primitives
    output logic                          dl_rel_confirm_o,
    output logic                          dl_rel_ind_o,
    output logic                          flush_ui_o,
    output logic                          flush_i_o,
    output logic                          tei_assigned_o,
    output logic                          assign_start_o,
    output logic                          user_action_o
);

    // A zero-cycle timer wraps before it reaches its expiry count; one cycle is refused as well
    if (T202_CYC < 2) begin : g_t202_check
        $error("T202_CYC out of range");
    end


    function automatic logic ai_hits(input logic [6:0] ai, input logic [6:0] tei);
        ai_hits = (ai == tei) || (ai == `TEI_GROUP);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [2:0]  ctrl_q;
    logic [6:0]  tei_q;
    logic        tei_valid_q;
    logic [31:0] t202_q;
    logic        verify_wr;
    logic        tei_wr;
    logic        vf_busy_q;
    logic        vf_try_q;
    tei_codec_pkg::rm_state_t rm_state_q;

    assign verify_wr = reg_wr_i && reg_addr_i == `REG_CTRL && reg_wdata_i[`CTRL_VERIFY];
    assign tei_wr    = reg_wr_i && reg_addr_i == `REG_TEI;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_q <= `CTRL_RESET;
            t202_q <= T202_CYC;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `REG_CTRL) begin
                ctrl_q <= {reg_wdata_i[`CTRL_DUP_REMOVE], reg_wdata_i[`CTRL_AUTO], 1'b0};
            end
            if (reg_addr_i == `REG_T202 && reg_wdata_i > 32'h1) begin
                t202_q <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `REG_CTRL:   reg_rdata_o <= {29'h0, ctrl_q};
                `REG_TEI:    reg_rdata_o <= {24'h0, tei_valid_q, tei_q};
                `REG_T202:   reg_rdata_o <= t202_q;
                `REG_STATUS: reg_rdata_o <= {24'h0, rm_state_q, user_action_o,
                                             vf_try_q, vf_busy_q, tei_valid_q};
                default:     reg_rdata_o <= 32'h0;
            endcase
        end else begin
            reg_rdata_o <= 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Disconnect pin: three stages, a change counts once stages two and three agree
    logic [2:0] disc_sync_q;
    logic       disc_lvl_q;
    logic       disc_ev_q;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            disc_sync_q <= 3'h0;
            disc_lvl_q  <= 1'b0;
            disc_ev_q   <= 1'b0;
        end else begin
            disc_sync_q <= {disc_sync_q[1:0], phy_disc_i};
            if (disc_sync_q[1] == disc_sync_q[2]) begin
                disc_lvl_q <= disc_sync_q[2];
            end
            disc_ev_q <= (disc_sync_q[1] == disc_sync_q[2]) && disc_sync_q[2] && !disc_lvl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Receive parser
    logic       hdr_ok_q;
    logic [2:0] rx_idx_q;
    logic [7:0] mei_q;
    logic [7:0] mt_q;
    logic [6:0] ai_q;
    logic       done_q;
    logic       len_ok_q;
    logic       msg_ok;
    logic       hdr_ok;

    assign hdr_ok = rx_hdr_i.ui_cmd && rx_hdr_i.sapi == `TEI_MGMT_SAPI
                    && rx_hdr_i.tei == `TEI_GROUP;

    // Ri and trailing Ai octets are never stored: the user side needs neither
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hdr_ok_q <= 1'b0;
            rx_idx_q <= 3'h0;
            mei_q    <= 8'h00;
            mt_q     <= 8'h00;
            ai_q     <= 7'h00;
            done_q   <= 1'b0;
            len_ok_q <= 1'b0;
        end else begin
            done_q <= rx_valid_i && rx_eof_i;
            if (rx_valid_i) begin
                if (rx_sof_i) begin
                    hdr_ok_q <= hdr_ok;
                    mei_q    <= rx_data_i;
                    rx_idx_q <= 3'h1;
                end else if (rx_idx_q != 3'h7) begin
                    rx_idx_q <= rx_idx_q + 3'h1;
                end
                if (!rx_sof_i && rx_idx_q == 3'h3) begin
                    mt_q <= rx_data_i;
                end
                if (!rx_sof_i && rx_idx_q == 3'h4) begin
                    ai_q <= rx_data_i[7:1];
                end
                len_ok_q <= !rx_sof_i && rx_idx_q >= 3'h4;
            end
        end
    end

    assign msg_ok = done_q && hdr_ok_q && len_ok_q && mei_q == `TEI_MEI
                    && mt_q >= `MT_ID_REQ && mt_q <= `MT_ID_VERIFY;

    logic rx_remove;
    logic rx_chk;
    logic rx_dup;

    assign rx_remove = msg_ok && mt_q == `MT_ID_REMOVE && tei_valid_q
                       && ai_hits(ai_q, tei_q);
    assign rx_chk    = msg_ok && mt_q == `MT_CHK_REQ && tei_valid_q && ai_hits(ai_q, tei_q);
    assign rx_dup    = msg_ok && mt_q == `MT_ID_ASSIGNED && tei_valid_q
                       && ctrl_q[`CTRL_DUP_REMOVE] && ai_q == tei_q;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Verify procedure and T202
    logic [31:0] tmr_q;
    logic        tmr_run_q;
    logic        tmr_exp;
    logic        vf_lose;
    logic        vf_pend_q;
    logic        verify_sent;

    assign tmr_exp = tmr_run_q && tmr_q == 32'h1;
    assign vf_lose = vf_busy_q && tmr_exp && vf_try_q;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            vf_busy_q <= 1'b0;
            vf_try_q  <= 1'b0;
            tmr_q     <= 32'h0;
            tmr_run_q <= 1'b0;
        end else begin
            if (tmr_run_q) begin
                tmr_q <= tmr_q - 32'h1;
            end
            if (verify_wr && tei_valid_q && !vf_busy_q) begin
                vf_busy_q <= 1'b1;
                vf_try_q  <= 1'b0;
            end else if (vf_busy_q && rx_chk) begin
                vf_busy_q <= 1'b0;
                tmr_run_q <= 1'b0;
            end else if (tmr_exp) begin
                tmr_run_q <= 1'b0;
                vf_try_q  <= 1'b1;
                vf_busy_q <= !vf_try_q;
            end else if (rm_state_q == tei_codec_pkg::RM_NEXT) begin
                vf_busy_q <= 1'b0;
                tmr_run_q <= 1'b0;
            end
            if (verify_sent && vf_busy_q) begin
                tmr_q     <= t202_q;
                tmr_run_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Transmit: one 5-octet message at a time, verify ahead of check response
    logic        ck_pend_q;
    logic        tx_busy_q;
    logic        tx_sel_q;
    logic [2:0]  tx_idx_q;
    logic [15:0] lfsr_q;
    logic [15:0] tx_ri_q;
    logic        tx_adv;

    function automatic logic [7:0] tx_octet(input logic [2:0] idx, input logic sel,
                                            input logic [15:0] ri, input logic [6:0] ai);
        unique case (idx)
            3'h0:    tx_octet = `TEI_MEI;
            3'h1:    tx_octet = ri[15:8];
            3'h2:    tx_octet = ri[7:0];
            3'h3:    tx_octet = sel ? `MT_ID_VERIFY : `MT_CHK_RSP;
            default: tx_octet = {ai, 1'b1};
        endcase
    endfunction

    assign tx_adv      = tx_busy_q && tx_ready_i;
    assign verify_sent = tx_adv && tx_sel_q && tx_idx_q == 3'h4;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            lfsr_q <= 16'hACE1;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            vf_pend_q <= 1'b0;
            ck_pend_q <= 1'b0;
            tx_busy_q <= 1'b0;
            tx_sel_q  <= 1'b0;
            tx_idx_q  <= 3'h0;
            tx_ri_q   <= 16'h0000;
            tx_o      <= '0;
            tx_hdr_o  <= '0;
        end else begin
            tx_hdr_o <= '{ui_cmd: 1'b1, sapi: `TEI_MGMT_SAPI, tei: `TEI_GROUP};
            if (!tx_busy_q && (vf_pend_q || ck_pend_q)) begin
                tx_busy_q <= 1'b1;
                tx_sel_q  <= vf_pend_q;
                tx_idx_q  <= 3'h0;
                // Verify Ri is zero; a random Ri separates colliding responses
                tx_ri_q   <= vf_pend_q ? 16'h0000 : lfsr_q;
                tx_o      <= '{valid: 1'b1, last: 1'b0, data: `TEI_MEI};
                if (vf_pend_q) begin
                    vf_pend_q <= 1'b0;
                end else begin
                    ck_pend_q <= 1'b0;
                end
            end else if (tx_adv) begin
                tx_idx_q <= tx_idx_q + 3'h1;
                tx_o     <= '{valid: tx_idx_q != 3'h4, last: tx_idx_q == 3'h3,
                              data: tx_idx_q == 3'h4 ? 8'h00
                                  : tx_octet(tx_idx_q + 3'h1, tx_sel_q, tx_ri_q, tei_q)};
                if (tx_idx_q == 3'h4) begin
                    tx_busy_q <= 1'b0;
                end
            end
            // Set after clear so a same-cycle request survives
            if (verify_wr && tei_valid_q && !vf_busy_q || vf_busy_q && tmr_exp && !vf_try_q) begin
                vf_pend_q <= 1'b1;
            end
            // Single held TEI, so a group check is answered by one full list
            if (rx_chk) begin
                ck_pend_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Removal sequence
    logic rel_pend_q;
    logic rm_go;

    assign rm_go = tei_valid_q && (rx_remove || disc_ev_q || mdl_multi_err_i
                                   || rx_dup || vf_lose);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rel_pend_q <= 1'b0;
        end else if (dl_rel_req_i) begin
            rel_pend_q <= 1'b1;
        end else if (rm_state_q == tei_codec_pkg::RM_REL || !dl_mf_est_i) begin
            rel_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rm_state_q       <= tei_codec_pkg::RM_IDLE;
            dl_rel_confirm_o <= 1'b0;
            dl_rel_ind_o     <= 1'b0;
            flush_ui_o       <= 1'b0;
            flush_i_o        <= 1'b0;
            assign_start_o   <= 1'b0;
        end else begin
            dl_rel_confirm_o <= 1'b0;
            dl_rel_ind_o     <= 1'b0;
            flush_ui_o       <= 1'b0;
            flush_i_o        <= 1'b0;
            assign_start_o   <= 1'b0;
            unique case (rm_state_q)
                tei_codec_pkg::RM_IDLE: begin
                    if (rm_go) begin
                        rm_state_q <= tei_codec_pkg::RM_REL;
                    end
                end
                tei_codec_pkg::RM_REL: begin
                    dl_rel_confirm_o <= rel_pend_q;
                    dl_rel_ind_o     <= !rel_pend_q && dl_mf_est_i;
                    rm_state_q       <= tei_codec_pkg::RM_FLUSH;
                end
                tei_codec_pkg::RM_FLUSH: begin
                    flush_ui_o <= 1'b1;
                    flush_i_o  <= 1'b1;
                    rm_state_q <= tei_codec_pkg::RM_NEXT;
                end
                tei_codec_pkg::RM_NEXT: begin
                    assign_start_o <= ctrl_q[`CTRL_AUTO];
                    rm_state_q     <= tei_codec_pkg::RM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tei_q          <= `TEI_RESET;
            tei_valid_q    <= 1'b0;
            tei_assigned_o <= 1'b0;
            user_action_o  <= 1'b0;
        end else begin
            tei_assigned_o <= tei_valid_q;
            if (rm_state_q == tei_codec_pkg::RM_NEXT) begin
                tei_valid_q <= 1'b0;
                if (!ctrl_q[`CTRL_AUTO]) begin
                    user_action_o <= 1'b1;
                end
            end else if (tei_wr && rm_state_q == tei_codec_pkg::RM_IDLE) begin
                tei_q         <= reg_wdata_i[6:0];
                tei_valid_q   <= reg_wdata_i[`TEI_VALID_BIT];
                user_action_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks
    tx_first_octet_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tx_o.valid && tx_idx_q == 3'h0 |-> tx_o.data == 8'h0F)
        else $error("first octet is not the entity identifier");
    tx_frame_addr_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tx_o.valid |-> tx_hdr_o.ui_cmd && tx_hdr_o.sapi == 6'h3F && tx_hdr_o.tei == 7'h7F)
        else $error("message not in UI frame to SAPI 63 TEI 127");
    verify_fields_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tx_o.valid && tx_sel_q && (tx_idx_q == 3'h1 || tx_idx_q == 3'h2)
        |-> tx_o.data == 8'h00)
        else $error("verify reference number not zero");
    ai_final_bit_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tx_o.valid && tx_idx_q == 3'h4 |-> tx_o.data[0] && tx_o.last)
        else $error("single Ai octet lacks final mark");
    release_kind_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rm_state_q == tei_codec_pkg::RM_REL && rel_pend_q |=> dl_rel_confirm_o && !dl_rel_ind_o)
        else $error("pending release not confirmed");
    flush_order_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rm_state_q == tei_codec_pkg::RM_REL |=> ##1 flush_ui_o && flush_i_o ##1 !tei_valid_q)
        else $error("queues not flushed before unassigned");
    t202_stop_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        vf_busy_q && rx_chk && !verify_wr |=> !vf_busy_q && !tmr_run_q)
        else $error("matching check request did not stop T202");
    second_expiry_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        vf_lose && rm_state_q == tei_codec_pkg::RM_IDLE |=> rm_state_q == tei_codec_pkg::RM_REL)
        else $error("second T202 expiry did not remove TEI");
    bad_msg_drop_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        done_q && (mei_q != 8'h0F || mt_q == 8'h00 || mt_q > 8'h07)
        |-> !rx_remove && !rx_chk && !rx_dup)
        else $error("bad identifier message acted on");

endmodule

// file: design/tei_codec_params.svh
`ifndef TEI_CODEC_PARAMS_SVH
`define TEI_CODEC_PARAMS_SVH

// Frame address and entity identifier of every management message
`define TEI_MGMT_SAPI    6'h3F
`define TEI_GROUP        7'h7F
`define TEI_MEI          8'h0F

// Message type codes
`define MT_ID_REQ        8'h01
`define MT_ID_ASSIGNED   8'h02
`define MT_ID_DENIED     8'h03
`define MT_CHK_REQ       8'h04
`define MT_CHK_RSP       8'h05
`define MT_ID_REMOVE     8'h06
`define MT_ID_VERIFY     8'h07

// Register offsets (byte addresses)
`define REG_CTRL         4'h0
`define REG_TEI          4'h4
`define REG_T202         4'h8
`define REG_STATUS       4'hC

// Control and TEI field positions
`define CTRL_VERIFY      0
`define CTRL_AUTO        1
`define CTRL_DUP_REMOVE  2
`define TEI_VALID_BIT    7

// Reset values
`define CTRL_RESET       3'h2
`define TEI_RESET        7'h00

// Timing
`define CLK_HZ           20000000
`define T202_MS          2000
`define T202_CYC         ((`CLK_HZ / 1000) * `T202_MS)

`endif

// file: design/tei_codec_pkg.sv
package tei_codec_pkg;

    typedef enum logic [3:0] {
        RM_IDLE  = 4'b0001,
        RM_REL   = 4'b0010,
        RM_FLUSH = 4'b0100,
        RM_NEXT  = 4'b1000
    } rm_state_t;

    // Data link address of a received or transmitted frame
    typedef struct packed {
        logic       ui_cmd;
        logic [5:0] sapi;
        logic [6:0] tei;
    } frame_hdr_t;

    // Outgoing message octet
    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } tx_octet_t;

endpackage

// file: verification/tei_net_model.sv
`timescale 1ns/1ps
`include "tei_codec_params.svh"
////////////////////////////////////////////////////////////////////////////////
module tei_net_model (
    // Clock
    input  wire logic                      clk_sys_i,
    // Frames toward the device
    output tei_codec_pkg::frame_hdr_t      rx_hdr_o,
    output logic                           rx_valid_o,
    output logic                           rx_sof_o,
    output logic                           rx_eof_o,
    output logic [7:0]                     rx_data_o,
    // Frames from the device
    input  wire tei_codec_pkg::tx_octet_t  tx_i,
    output logic                           tx_ready_o,
    input  wire logic                      slow_i
);
    logic [8:0] got_q[$];

    initial begin
        rx_hdr_o   = '0;
        rx_valid_o = 1'b0;
        rx_sof_o   = 1'b0;
        rx_eof_o   = 1'b0;
        rx_data_o  = 8'h00;
        tx_ready_o = 1'b1;
    end

    // Slow mode drops ready every other cycle
    always @(posedge clk_sys_i) begin
        if (tx_i.valid && tx_ready_o) begin
            got_q.push_back({tx_i.last, tx_i.data});
        end
        tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
    end

    task automatic send(input logic [7:0] mei, input logic [7:0] mt, input logic [6:0] ai);
        logic [7:0] oct [5];
        oct = '{mei, 8'h00, 8'h00, mt, {ai, 1'b1}};
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys_i);
            rx_hdr_o   <= '{1'b1, `TEI_MGMT_SAPI, `TEI_GROUP};
            rx_valid_o <= 1'b1;
            rx_sof_o   <= (i == 0);
            rx_eof_o   <= (i == 4);
            rx_data_o  <= oct[i];
        end
        // Released lines must not keep showing the last octet
        @(posedge clk_sys_i);
        rx_valid_o <= 1'b0;
        rx_sof_o   <= 1'b0;
        rx_eof_o   <= 1'b0;
        rx_data_o  <= ~oct[4];
        rx_hdr_o   <= '0;
    endtask

    // Remove always goes out twice in a row
    task automatic remove(input logic [6:0] ai);
        send(`TEI_MEI, `MT_ID_REMOVE, ai);
        send(`TEI_MEI, `MT_ID_REMOVE, ai);
    endtask
endmodule

// file: verification/tei_removal_verify_codec_tb_top.sv
`timescale 1ns/1ps
`include "tei_codec_params.svh"
////////////////////////////////////////////////////////////////////////////////
module tei_removal_verify_codec_tb_top;
    logic clk_sys_i, rst_i, reg_wr, reg_rd, phy_disc, multi_err, rel_req, mf_est, slow;
    logic rel_cnf, rel_ind, fl_ui, fl_i, tei_asg, asg_start, usr_act;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    tei_codec_pkg::frame_hdr_t rx_hdr, tx_hdr;
    tei_codec_pkg::tx_octet_t tx;
    logic rx_valid, rx_sof, rx_eof, tx_ready;
    logic [7:0] rx_data;
    logic [6:0] tei;
    int miscompares, n_checks, n_asg, n_ind, n_cnf, n_fl, a, b;
    integer seed = 32'h5923f602;

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    tei_removal_verify_codec dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .rx_hdr_i(rx_hdr),
        .rx_valid_i(rx_valid), .rx_sof_i(rx_sof), .rx_eof_i(rx_eof), .rx_data_i(rx_data),
        .tx_hdr_o(tx_hdr), .tx_o(tx), .tx_ready_i(tx_ready), .phy_disc_i(phy_disc),
        .mdl_multi_err_i(multi_err), .dl_rel_req_i(rel_req), .dl_mf_est_i(mf_est),
        .dl_rel_confirm_o(rel_cnf), .dl_rel_ind_o(rel_ind), .flush_ui_o(fl_ui),
        .flush_i_o(fl_i), .tei_assigned_o(tei_asg), .assign_start_o(asg_start),
        .user_action_o(usr_act));

    tei_net_model net (
        .clk_sys_i(clk_sys_i), .rx_hdr_o(rx_hdr), .rx_valid_o(rx_valid), .rx_sof_o(rx_sof),
        .rx_eof_o(rx_eof), .rx_data_o(rx_data), .tx_i(tx), .tx_ready_o(tx_ready),
        .slow_i(slow));

    always @(posedge clk_sys_i) begin
        if (asg_start === 1'b1) n_asg++;
        if (rel_ind === 1'b1) n_ind++;
        if (rel_cnf === 1'b1) n_cnf++;
        if (fl_ui === 1'b1 && fl_i === 1'b1) n_fl++;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr  <= ad;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr    <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [3:0] ad, input logic [31:0] exp);
        @(posedge clk_sys_i);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd   <= 1'b0;
        // Taken at the edge that ends the one cycle in which the data stand
        @(posedge clk_sys_i);
        chk(what, reg_rdata, exp);
    endtask

    // Ri of a check response is random, so only verify Ri is compared
    task automatic get_msg(input logic [7:0] mt, input logic [6:0] ai);
        logic [8:0] m [5];
        int w;
        w = 0;
        while (net.got_q.size() < 5 && w < 500) begin
            @(posedge clk_sys_i);
            w++;
        end
        if (w >= 500) chk("tx message", 0, 1);
        else begin
            foreach (m[i]) m[i] = net.got_q.pop_front();
            chk("mei", m[0], {1'b0, `TEI_MEI});
            if (mt == `MT_ID_VERIFY) chk("verify ri", {m[1], m[2]}, 0);
            chk("type", m[3], {1'b0, mt});
            chk("ai", m[4], {1'b1, ai, 1'b1});
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        miscompares++;
        give_verdict();
    end

    initial begin
        {rst_i, reg_wr, reg_rd, phy_disc, multi_err, rel_req, mf_est} = 7'h01 << 6;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        slow = 1'b0;
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        tei = 7'($unsigned($random(seed)) % 127);
        slow <= 1'($random(seed));
        rchk("ctrl rst", `REG_CTRL, 32'h2);
        chk("tx hdr", {18'h0, tx_hdr}, {18'h0, 1'b1, 6'h3F, 7'h7F});
        rchk("t202 rst", `REG_T202, 32'h02625A00);
        rchk("stat rst", `REG_STATUS, 32'h10);
        rchk("unmapped", 4'h2, 32'h0);
        wr(`REG_TEI, {24'h0, 1'b1, tei});
        wr(`REG_T202, 32'd20);
        chk("tei asg", tei_asg, 1);
        a = n_asg;
        wr(`REG_CTRL, 32'h3);
        get_msg(`MT_ID_VERIFY, tei);
        get_msg(`MT_ID_VERIFY, tei);
        repeat (40) @(posedge clk_sys_i);
        chk("expiry removal", n_asg, a + 1);
        rchk("stat unasg", `REG_STATUS, 32'h14);
        wr(`REG_TEI, {24'h0, 1'b1, tei});
        wr(`REG_CTRL, 32'h3);
        get_msg(`MT_ID_VERIFY, tei);
        net.send(`TEI_MEI, `MT_CHK_REQ, tei);
        get_msg(`MT_CHK_RSP, tei);
        net.send(`TEI_MEI, `MT_CHK_REQ, 7'h7F);
        get_msg(`MT_CHK_RSP, tei);
        repeat (60) @(posedge clk_sys_i);
        rchk("t202 stop", `REG_STATUS, 32'h11);
        net.send(8'h0E, `MT_ID_REMOVE, 7'h7F);
        net.send(`TEI_MEI, 8'h08, 7'h7F);
        repeat (10) @(posedge clk_sys_i);
        rchk("bad msg", `REG_STATUS, 32'h11);
        mf_est <= 1'b1;
        a = n_ind;
        b = n_fl;
        net.remove(7'h7F);
        chk("rel ind", n_ind, a + 1);
        chk("flush", n_fl, b + 1);
        rchk("remove", `REG_STATUS, 32'h10);
        wr(`REG_TEI, {24'h0, 1'b1, tei});
        a = n_cnf;
        b = n_ind;
        rel_req <= 1'b1;
        @(posedge clk_sys_i);
        rel_req <= 1'b0;
        multi_err <= 1'b1;
        @(posedge clk_sys_i);
        multi_err <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        chk("rel cnf", n_cnf, a + 1);
        chk("no ind", n_ind, b);
        wr(`REG_TEI, {24'h0, 1'b1, tei});
        wr(`REG_CTRL, 32'h0);
        phy_disc <= 1'b1;
        repeat (20) @(posedge clk_sys_i);
        chk("user act", usr_act, 1);
        rchk("disc", `REG_STATUS, 32'h18);
        phy_disc <= 1'b0;
        wr(`REG_TEI, {24'h0, 1'b1, tei});
        #1 chk("act clr", usr_act, 0);
        wr(`REG_CTRL, 32'h6);
        a = n_asg;
        net.send(`TEI_MEI, `MT_ID_ASSIGNED, tei);
        repeat (8) @(posedge clk_sys_i);
        chk("dup remove", n_asg, a + 1);
        give_verdict();
    end
endmodule
